//--- pkg/tmon_pkg.sv
package tmon_pkg;
    // Register byte addresses (index times four)
    localparam logic [7:0] A_CMD      = 8'h00;
    localparam logic [7:0] A_RESULT   = 8'h04;
    localparam logic [7:0] A_T1       = 8'h08;
    localparam logic [7:0] A_T2       = 8'h0C;
    localparam logic [7:0] A_TINT     = 8'h10;
    localparam logic [7:0] A_ALERT_C  = 8'h1C;
    localparam logic [7:0] A_CFG      = 8'h24;
    localparam logic [7:0] A_PWRDN    = 8'h28;
    localparam logic [7:0] A_OFS1     = 8'h98;
    localparam logic [7:0] A_OFS2     = 8'hA0;
    localparam logic [7:0] A_DAC0     = 8'hB0;
    localparam logic [7:0] A_STATUS   = 8'hC0;
    // Field positions
    localparam int CMD_T1_BIT     = 6;
    localparam int CMD_T2_BIT     = 7;
    localparam int CFG_AUTO_BIT   = 0;
    localparam int PD_TSENSE_BIT  = 3;
    localparam int PD_REFA_BIT    = 4;
    localparam int PD_REFD_BIT    = 5;
    localparam int ALC_OVT_BIT    = 0;
    // Reset values
    localparam logic [7:0] PWRDN_RST = 8'h30;
    // Timing
    localparam int CLK_HZ         = 50_000_000;
    localparam int TEMP_PERIOD_MS = 5;
    localparam int TEMP_SLOT_CYC  = CLK_HZ / 1000 * TEMP_PERIOD_MS / 3;
    localparam int CONV_CYC       = 150;
    localparam int AUTO_SEQ_LEN   = 4;
    // Die shutdown threshold, 150 C at 0.25 C per LSB
    localparam logic [11:0] OVT_CODE = 12'h258;
    typedef enum logic [3:0]
    {
        S_IDLE = 4'b0001,
        S_USER = 4'b0010,
        S_TEMP = 4'b0100,
        S_GAP  = 4'b1000
    } conv_state_t;
endpackage

//--- src/temp_req_queue.sv
`timescale 1ns/1ps
module temp_req_queue
(
    input  wire logic       mclk,    // Clock
    input  wire logic       arst_n,  // Async reset
    input  wire logic       push,    // New request
    input  wire logic [1:0] push_ch, // Channel of request
    input  wire logic       pop,     // Request taken
    output logic            pend,    // Request waiting
    output logic [1:0]      head_ch  // Channel at head
);
    logic [1:0] ch_r [0:3];
    logic [2:0] cnt_r;
    logic [1:0] rd_r;
    logic [1:0] wr_r;

    // Four slots: the round robin can never stack more than three
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= 3'h0;
            rd_r  <= 2'h0;
            wr_r  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                ch_r[wr_r] <= push_ch;
                wr_r       <= wr_r + 2'h1;
            end
            if (pop && cnt_r != 3'h0)
                rd_r <= rd_r + 2'h1;
            cnt_r <= cnt_r + {2'h0, push} - {2'h0, pop && cnt_r != 3'h0};
        end
    end

    assign pend    = cnt_r != 3'h0;
    assign head_ch = ch_r[rd_r];
endmodule

//--- src/dac_tap_decode.sv
`timescale 1ns/1ps
module dac_tap_decode #(parameter int W = 12)
(
    input  wire logic [W-1:0]      code,  // Stored DAC code
    output logic [(1<<W)-1:0]      taps   // One-hot tap select
);
    logic [W-1:0] inv;
    // Inverted so the offset amplifier output rises with code
    assign inv  = ~code;
    assign taps = {{((1<<W)-1){1'b0}}, 1'b1} << inv;
endmodule

//--- src/temp_monitor_scheduler.sv
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module temp_monitor_scheduler #(
    parameter int SLOT_CYC = tmon_pkg::TEMP_SLOT_CYC, // Cycles per channel integration
    parameter int CONV     = tmon_pkg::CONV_CYC       // Cycles per conversion
)
(
    input  wire logic        mclk,         // 50 MHz clock
    input  wire logic        arst_n,       // Async reset, active low
    input  wire logic [31:0] haddr,        // AHB address
    input  wire logic [1:0]  htrans,       // AHB transfer type
    input  wire logic        hwrite,       // AHB write
    input  wire logic [2:0]  hsize,        // AHB size
    input  wire logic [31:0] hwdata,       // AHB write data
    input  wire logic        hsel,         // AHB select
    input  wire logic        hready,       // AHB bus ready
    input  wire logic [11:0] adc_code,     // Raw converter result
    output logic [31:0]      hrdata,       // AHB read data
    output logic             hreadyout,    // AHB slave ready
    output logic             hresp,        // AHB response, always OKAY
    output logic             conv_start,   // Converter start pulse
    output logic [2:0]       conv_ch,      // Channel being converted
    output logic             dac_hiz,      // DAC outputs high impedance
    output logic             int_ref_adc,  // ADC internal reference on
    output logic             int_ref_dac,  // DAC internal reference on
    output logic [4095:0]    dac_taps      // DAC0 one-hot string taps
);
    localparam logic [2:0] CH_T1   = 3'h4;
    localparam logic [2:0] CH_T2   = 3'h5;
    localparam logic [2:0] CH_TINT = 3'h6;

    // Bus address phase capture
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [7:0]  addr_r;
    logic        bus_go;
    assign bus_go = hsel && hready && htrans[1];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end
        else
        begin
            wr_pend_r <= bus_go && hwrite;
            rd_pend_r <= bus_go && !hwrite;
            if (bus_go)
                addr_r <= haddr[7:0];
        end
    end

    // Software registers
    logic [7:0]  cmd_r;
    logic        cmd_mode_r;
    logic [7:0]  cfg_r;
    logic [7:0]  pwrdn_r;
    logic [11:0] ofs1_r;
    logic [11:0] ofs2_r;
    logic [11:0] dac0_r;
    logic        wr_cmd;
    assign wr_cmd = wr_pend_r && addr_r == tmon_pkg::A_CMD;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_r      <= 8'h00;
            cmd_mode_r <= 1'b0;
            cfg_r      <= 8'h00;
            pwrdn_r    <= tmon_pkg::PWRDN_RST;
            ofs1_r     <= 12'h000;
            ofs2_r     <= 12'h000;
            dac0_r     <= 12'h000;
        end
        else if (wr_pend_r)
        begin
            unique case (addr_r)
                tmon_pkg::A_CMD:
                begin
                    cmd_r      <= hwdata[7:0];
                    cmd_mode_r <= 1'b1;
                end
                tmon_pkg::A_CFG:   cfg_r   <= hwdata[7:0];
                tmon_pkg::A_PWRDN: pwrdn_r <= hwdata[7:0];
                tmon_pkg::A_OFS1:  ofs1_r  <= hwdata[11:0];
                tmon_pkg::A_OFS2:  ofs2_r  <= hwdata[11:0];
                tmon_pkg::A_DAC0:  dac0_r  <= hwdata[11:0];
                default:
                begin
                end
            endcase
        end
    end

    // Integration interval and round robin
    logic [31:0] slot_cnt_r;
    logic [1:0]  rr_r;
    logic        integ_done;
    assign integ_done = slot_cnt_r == 32'(SLOT_CYC - 1);

    // Each channel integrates one third of the 5 ms refresh period
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            slot_cnt_r <= 32'h0000_0000;
            rr_r       <= 2'h0;
        end
        else if (integ_done)
        begin
            slot_cnt_r <= 32'h0000_0000;
            rr_r       <= (rr_r == 2'h2) ? 2'h0 : rr_r + 2'h1;
        end
        else
            slot_cnt_r <= slot_cnt_r + 32'h0000_0001;
    end

    // Pending temperature requests
    logic       t_pend;
    logic [1:0] t_head;
    logic       t_pop;
    temp_req_queue u_q
    (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .push    (integ_done),
        .push_ch (rr_r),
        .pop     (t_pop),
        .pend    (t_pend),
        .head_ch (t_head)
    );

    // Conversion scheduler
    tmon_pkg::conv_state_t st_r;
    logic [7:0]  busy_cnt_r;
    logic [1:0]  seq_idx_r;
    logic [1:0]  cur_t_r;
    logic        cmd_go_r;
    logic        user_req;
    logic        auto_on;
    logic        conv_done;
    assign auto_on   = cfg_r[tmon_pkg::CFG_AUTO_BIT] && !cmd_mode_r;
    assign user_req  = cmd_go_r || auto_on;
    assign conv_done = busy_cnt_r == 8'(CONV - 1);
    // Temperature wins at every boundary, so it lands between user slots
    assign t_pop     = t_pend && (st_r == tmon_pkg::S_IDLE || st_r == tmon_pkg::S_GAP);

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r       <= tmon_pkg::S_IDLE;
            busy_cnt_r <= 8'h00;
            seq_idx_r  <= 2'h0;
            cur_t_r    <= 2'h0;
            conv_start <= 1'b0;
            conv_ch    <= 3'h0;
            cmd_go_r   <= 1'b0;
        end
        else
        begin
            conv_start <= 1'b0;
            unique case (st_r)
                tmon_pkg::S_IDLE, tmon_pkg::S_GAP:
                begin
                    busy_cnt_r <= 8'h00;
                    if (t_pend)
                    begin
                        st_r       <= tmon_pkg::S_TEMP;
                        cur_t_r    <= t_head;
                        conv_ch    <= 3'h4 + {1'b0, t_head};
                        conv_start <= 1'b1;
                    end
                    else if (user_req)
                    begin
                        st_r       <= tmon_pkg::S_USER;
                        conv_ch    <= {1'b0, seq_idx_r};
                        seq_idx_r  <= seq_idx_r + 2'h1;
                        cmd_go_r   <= 1'b0;
                        conv_start <= 1'b1;
                    end
                    else
                        st_r <= tmon_pkg::S_IDLE;
                end
                tmon_pkg::S_USER:
                begin
                    busy_cnt_r <= busy_cnt_r + 8'h01;
                    if (conv_done)
                        st_r <= tmon_pkg::S_GAP;
                end
                tmon_pkg::S_TEMP:
                begin
                    busy_cnt_r <= busy_cnt_r + 8'h01;
                    if (conv_done)
                        st_r <= tmon_pkg::S_GAP;
                end
            endcase
            if (wr_cmd && hwdata[5:0] != 6'h00)
                cmd_go_r <= 1'b1; // remote bits alone start nothing
        end
    end

    // Result storage with offset correction on T1 and T2; the die result is stored raw
    logic [11:0] t1_r;
    logic [11:0] t2_r;
    logic [11:0] tint_r;
    logic        t_store;
    assign t_store = st_r == tmon_pkg::S_TEMP && conv_done;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            t1_r   <= 12'h000;
            t2_r   <= 12'h000;
            tint_r <= 12'h000;
        end
        else if (t_store)
        begin
            unique case (cur_t_r)
                2'h0:    t1_r   <= adc_code + ofs1_r;
                2'h1:    t2_r   <= adc_code + ofs2_r;
                default: tint_r <= adc_code;
            endcase
        end
    end

    // Die overtemperature; sensor power-down disables it
    logic ovt_now;
    logic alert_ovt_r;
    logic clr_alert;
    assign ovt_now   = !pwrdn_r[tmon_pkg::PD_TSENSE_BIT] && tint_r > tmon_pkg::OVT_CODE;
    assign clr_alert = wr_pend_r && addr_r == tmon_pkg::A_ALERT_C
                       && hwdata[tmon_pkg::ALC_OVT_BIT];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            alert_ovt_r <= 1'b0;
            dac_hiz     <= 1'b0;
        end
        else
        begin
            dac_hiz <= ovt_now;
            // Set wins over a clear in the same cycle
            if (ovt_now)
                alert_ovt_r <= 1'b1;
            else if (clr_alert)
                alert_ovt_r <= 1'b0;
        end
    end

    // Reference selection, effective only with both bits clear
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            int_ref_adc <= 1'b0;
            int_ref_dac <= 1'b0;
        end
        else
        begin
            int_ref_adc <= pwrdn_r[5:4] == 2'b00;
            int_ref_dac <= pwrdn_r[5:4] == 2'b00;
        end
    end

    // DAC tap decode, registered for glitch-free switching
    logic [4095:0] taps;
    dac_tap_decode #(.W(12)) u_dec
    (
        .code (dac0_r),
        .taps (taps)
    );
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            dac_taps <= {1'b1, {4095{1'b0}}}; // Decode of reset code, no tap move at release
        else
            dac_taps <= taps;
    end

    // Command-mode read sequence over selected remote results
    logic [1:0] rd_ptr_r;
    logic       rd_seq;
    assign rd_seq = rd_pend_r && addr_r == tmon_pkg::A_RESULT;

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rd_ptr_r <= 2'h0;
        else if (wr_cmd)
            rd_ptr_r <= 2'h0;
        else if (rd_seq)
            rd_ptr_r <= rd_ptr_r + 2'h1;
    end

    // Read data mux; sequence entries return stored background values
    function automatic logic [31:0] seq_word(input logic [7:0] c, input logic [1:0] p,
                                             input logic [11:0] a, input logic [11:0] b);
        logic lo;
        logic hi;
        lo = c[tmon_pkg::CMD_T1_BIT];
        hi = c[tmon_pkg::CMD_T2_BIT];
        seq_word = 32'h0000_0000;
        if (lo && (p[0] == 1'b0 || !hi))
            seq_word = {17'h00000, CH_T1, a};
        else if (hi)
            seq_word = {17'h00000, CH_T2, b};
    endfunction

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            hrdata <= 32'h0000_0000;
        else if (bus_go && !hwrite)
        begin
            unique case (haddr[7:0])
                tmon_pkg::A_RESULT:  hrdata <= seq_word(cmd_r, rd_ptr_r, t1_r, t2_r);
                tmon_pkg::A_T1:      hrdata <= {20'h00000, t1_r};
                tmon_pkg::A_T2:      hrdata <= {20'h00000, t2_r};
                tmon_pkg::A_TINT:    hrdata <= {20'h00000, tint_r};
                tmon_pkg::A_ALERT_C: hrdata <= {31'h0000_0000, alert_ovt_r};
                tmon_pkg::A_CFG:     hrdata <= {24'h000000, cfg_r};
                tmon_pkg::A_PWRDN:   hrdata <= {24'h000000, pwrdn_r};
                tmon_pkg::A_OFS1:    hrdata <= {20'h00000, ofs1_r};
                tmon_pkg::A_OFS2:    hrdata <= {20'h00000, ofs2_r};
                tmon_pkg::A_DAC0:    hrdata <= {20'h00000, dac0_r};
                tmon_pkg::A_STATUS:  hrdata <= {27'h0000000, cmd_mode_r, st_r};
                default:             hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
endmodule

//--- sim/tmon_sva.sv
`timescale 1ns/1ps
// Pin-level checks on the scheduler
module tmon_sva
(
    input logic          mclk,        // Clock
    input logic          arst_n,      // Reset
    input logic [31:0]   haddr,       // Address
    input logic [1:0]    htrans,      // Type
    input logic          hwrite,      // Write
    input logic [2:0]    hsize,       // Size
    input logic [31:0]   hwdata,      // Wdata
    input logic          hsel,        // Select
    input logic          hready,      // Ready
    input logic [11:0]   adc_code,    // Result
    input logic [31:0]   hrdata,      // Rdata
    input logic          hreadyout,   // Ready out
    input logic          hresp,       // Response
    input logic          conv_start,  // Start
    input logic [2:0]    conv_ch,     // Channel
    input logic          dac_hiz,     // Tristate
    input logic          int_ref_adc, // ADC ref
    input logic          int_ref_dac, // DAC ref
    input logic [4095:0] dac_taps     // Taps
);
    logic wr;
    logic wr_pd;
    logic wr_dac;
    // Transfers taken at this edge
    assign wr     = hsel && hready && htrans[1] && hwrite;
    assign wr_pd  = wr && haddr[7:0] == tmon_pkg::A_PWRDN;
    assign wr_dac = wr && haddr[7:0] == tmon_pkg::A_DAC0;

    a_bus_okay: assert property (@(posedge mclk) disable iff (!arst_n)
        hreadyout && !hresp) else $error("bus answer not ready or not okay");
    a_start_spacing: assert property (@(posedge mclk) disable iff (!arst_n)
        conv_start |=> !conv_start [*8]) else $error("conversion restarted early");
    a_unmapped_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h40 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_refs_internal: assert property (@(posedge mclk) disable iff (!arst_n)
        wr_pd ##1 hwdata[5:4] == 2'b00 |-> ##[1:2] int_ref_adc && int_ref_dac)
        else $error("internal references not selected");
    a_refs_external: assert property (@(posedge mclk) disable iff (!arst_n)
        wr_pd ##1 hwdata[5:4] == 2'b11 |-> ##[1:2] !int_ref_adc && !int_ref_dac)
        else $error("external references not selected");
    a_taps_onehot: assert property (@(posedge mclk) disable iff (!arst_n)
        $onehot(dac_taps)) else $error("not exactly one tap closed");
    a_taps_cause: assert property (@(posedge mclk) disable iff (!arst_n)
        $changed(dac_taps) |-> $past(wr_dac, 2) || $past(wr_dac, 3) || $past(wr_dac))
        else $error("taps moved without a code write");
    a_hiz_cause: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(dac_hiz) |-> $past(conv_ch) == 3'd6 || $past(conv_ch, 2) == 3'd6)
        else $error("tristate without die conversion");
    a_hiz_sensor: assert property (@(posedge mclk) disable iff (!arst_n)
        wr_pd ##1 hwdata[3] |-> ##[2:3] !dac_hiz) else $error("tristate with sensor off");
endmodule

bind temp_monitor_scheduler tmon_sva u_sva (.mclk, .arst_n, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hsel, .hready, .adc_code, .hrdata, .hreadyout, .hresp,
    .conv_start, .conv_ch, .dac_hiz, .int_ref_adc, .int_ref_dac, .dac_taps);

//--- sim/adc_model.sv
`timescale 1ns/1ps
// Converter stand-in: a fixed code per channel, die code set by the bench
module adc_model
(
    input  wire logic        mclk,       // Clock
    input  wire logic        conv_start, // Start pulse
    input  wire logic [2:0]  conv_ch,    // Channel
    input  wire logic [11:0] die_code,   // Die sensor code
    output logic      [11:0] adc_code    // Result
);
    logic [11:0] code_r = 12'h000;
    // Code moves at each start, so a stale sample reads wrong
    always_ff @(posedge mclk)
    begin
        if (conv_start)
        begin
            case (conv_ch)
                3'd4:    code_r <= 12'h100;
                3'd5:    code_r <= 12'h200;
                3'd6:    code_r <= die_code;
                default: code_r <= {9'h0A0, conv_ch};
            endcase
        end
    end
    assign adc_code = code_r;
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic          mclk;
    logic          arst_n;
    logic [31:0]   haddr;
    logic [1:0]    htrans;
    logic          hwrite;
    logic [31:0]   hwdata;
    logic          hsel;
    logic [11:0]   adc_code;
    logic [11:0]   die_code;
    logic [31:0]   hrdata;
    logic          hreadyout;
    logic          hresp;
    logic          conv_start;
    logic [2:0]    conv_ch;
    logic          dac_hiz;
    logic          int_ref_adc;
    logic          int_ref_dac;
    logic [4095:0] dac_taps;
    logic [31:0]   rd;
    logic [11:0]   codes [3] = '{12'h000, 12'hFFF, 12'h5A3};
    logic [2:0]    tq [$];
    int            n_fail;
    int            comparisons;
    int            n_user;
    int            n0;

    temp_monitor_scheduler #(.SLOT_CYC(200), .CONV(10)) dut
    (
        .mclk, .arst_n, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hsel,
        .hready(hreadyout), .adc_code, .hrdata, .hreadyout, .hresp, .conv_start,
        .conv_ch, .dac_hiz, .int_ref_adc, .int_ref_dac, .dac_taps
    );
    adc_model conv (.mclk, .conv_start, .conv_ch, .die_code, .adc_code);

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Log every start: temperature channels in order, user ones counted
    always @(posedge mclk)
    begin
        if (conv_start === 1'b1 && conv_ch >= 3'd4)
            tq.push_back(conv_ch);
        else if (conv_start === 1'b1)
            n_user++;
    end

    task automatic summarize;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Waits are bounded so a dead slave ends the run
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge mclk);
        while (hreadyout !== 1'b1)
        begin
            k++;
            if (k > 50)
            begin
                n_fail++;
                summarize();
            end
            @(posedge mclk);
        end
    endtask

    // One single AHB transfer; read data taken at the data phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h0, a};
        wait_rdy();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask

    task automatic wait_hiz(input logic v);
        int k;
        k = 0;
        while (dac_hiz !== v)
        begin
            k++;
            if (k > 1000)
            begin
                n_fail++;
                summarize();
            end
            @(posedge mclk);
        end
    endtask

    initial
    begin
        arst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        die_code = 12'h190;
        n_fail = 0;
        comparisons = 0;
        n_user = 0;
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        chk({30'h0, int_ref_adc, int_ref_dac}, 32'h0);
        rdc(tmon_pkg::A_PWRDN, 32'hFF, 32'h30);
        rdc(8'h40, 32'hFFFFFFFF, 32'h0);
        bus(1'b1, tmon_pkg::A_OFS1, 32'hFF0);
        bus(1'b1, tmon_pkg::A_OFS2, 32'h010);
        cyc(700);
        // First round arrives unasked, in fixed order
        for (int i = 0; i < 3; i++)
            chk({29'h0, tq[i]}, 32'd4 + i);
        rdc(tmon_pkg::A_T1, 32'hFFF, 32'h0F0);
        rdc(tmon_pkg::A_T2, 32'hFFF, 32'h210);
        rdc(tmon_pkg::A_TINT, 32'hFFF, 32'h190);
        // Temperature slots keep coming while the user sequence runs
        n0 = tq.size();
        bus(1'b1, tmon_pkg::A_CFG, 32'h1);
        cyc(700);
        chk(32'(tq.size() - n0 >= 3 && n_user > 0), 32'h1);
        bus(1'b1, tmon_pkg::A_CFG, 32'h0);
        // Both remote bits: no conversion, results alternate
        n0 = n_user;
        bus(1'b1, tmon_pkg::A_CMD, 32'hC0);
        rdc(tmon_pkg::A_RESULT, 32'h7FFF, 32'h40F0);
        rdc(tmon_pkg::A_RESULT, 32'h7FFF, 32'h5210);
        rdc(tmon_pkg::A_RESULT, 32'h7FFF, 32'h40F0);
        rdc(tmon_pkg::A_STATUS, 32'h10, 32'h10);
        cyc(300);
        chk(32'(n_user - n0), 32'h0);
        // An ADC channel bit starts exactly one command conversion
        bus(1'b1, tmon_pkg::A_CMD, 32'h01);
        cyc(30);
        chk(32'(n_user - n0), 32'h1);
        rdc(tmon_pkg::A_T1, 32'hFFF, 32'h0F0);
        for (int i = 0; i < 3; i++)
        begin
            bus(1'b1, tmon_pkg::A_DAC0, {20'h0, codes[i]});
            cyc(3);
            chk(32'(dac_taps == (4096'h1 << ~codes[i])), 32'h1);
        end
        // Threshold itself is not over temperature
        die_code <= 12'h258;
        cyc(700);
        chk({31'h0, dac_hiz}, 32'h0);
        die_code <= 12'h259;
        wait_hiz(1'b1);
        rdc(tmon_pkg::A_ALERT_C, 32'h1, 32'h1);
        die_code <= 12'h190;
        wait_hiz(1'b0);
        bus(1'b1, tmon_pkg::A_ALERT_C, 32'h1);
        rdc(tmon_pkg::A_ALERT_C, 32'h1, 32'h0);
        bus(1'b1, tmon_pkg::A_PWRDN, 32'h38);
        die_code <= 12'h300;
        cyc(700);
        chk({31'h0, dac_hiz}, 32'h0);
        rdc(tmon_pkg::A_ALERT_C, 32'h1, 32'h0);
        die_code <= 12'h190;
        // Let a cool die result land before the sensor is back on
        cyc(700);
        bus(1'b1, tmon_pkg::A_PWRDN, 32'h00);
        cyc(3000);
        chk({30'h0, int_ref_adc, int_ref_dac}, 32'h3);
        bus(1'b1, tmon_pkg::A_PWRDN, 32'h30);
        cyc(5);
        chk({30'h0, int_ref_adc, int_ref_dac}, 32'h0);
        summarize();
    end
endmodule
